// file: src/apl_axis_guard.sv
/*
  axis supervision: hardware and software stroke limits, tracking deviation,
  touch-probe latch with window, drive error reset monitor, avalon-mm slave.
  assumes positions and operation strobes come from the motion core on clk_sys_i;
  limit, probe and drive error levels arrive from the drive link, unsynchronised.
*/
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "apl_consts.svh"
module apl_axis_guard #(
    parameter int unsigned MS_CYCLES   = `APL_MS_NS / `APL_CLK_NS,
    parameter logic [15:0] SW_ERR_CODE = 16'h0001
) (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // motion core, same clock
    input  wire logic [31:0] actual_pos_i,
    input  wire logic [31:0] target_pos_i,
    input  wire logic        pos_op_i,
    input  wire logic        speed_ctl_i,
    input  wire logic        homing_i,
    input  wire logic        torque_ctl_i,
    input  wire logic        rotary_i,
    input  wire logic        op_req_i,
    input  wire logic        op_jog_i,
    input  wire logic        op_dir_neg_i,
    // drive link levels, asynchronous
    input  wire logic        hw_upper_i,
    input  wire logic        hw_lower_i,
    input  wire logic        probe1_i,
    input  wire logic        probe2_i,
    input  wire logic        drive_err_i,
    // results
    output logic             motion_abort_o,
    output logic             sudden_stop_o,
    output logic             op_reject_o,
    output logic             drive_err_reset_o,
    output logic             deviation_warning_flag_o,
    output logic             deviation_alarm_flag_o,
    output logic      [15:0] error_code_out_o
);
    logic [7:0]  ctrl_q;
    logic [31:0] up_q, lo_q, tol_q, ws_q, we_q, lpos_q;
    logic [9:0]  mon_q, mcnt_q;
    logic [15:0] code_q;
    logic        wait_q, sel_q;
    apl_pkg::apl_flags_t fl_q, fl_d;
    apl_pkg::apl_rmon_t  rm_q;

    // synchronised pins: 0 upper, 1 lower, 2 drive error
    logic [2:0] lv, rs;
    logic [1:0] prs;
    logic       ms_tick;

    apl_sync_edge #(.W(3)) u_sync_lim (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .d_i       ({drive_err_i, hw_lower_i, hw_upper_i}),
        .lvl_o     (lv),
        .rise_o    (rs)
    );

    apl_sync_edge #(.W(2)) u_sync_prb (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .d_i       ({probe2_i, probe1_i}),
        .lvl_o     (),
        .rise_o    (prs)
    );

    // bus: waitrequest drops for one cycle, the request is taken at that edge
    wire req    = avs_read_i | avs_write_i;
    wire wr     = avs_write_i & ~wait_q;
    assign avs_waitrequest_o = wait_q;
    wire s_ctrl = avs_address_i == `APL_OFS_CTRL;
    wire s_up   = avs_address_i == `APL_OFS_SWUP;
    wire s_lo   = avs_address_i == `APL_OFS_SWLO;
    wire s_tol  = avs_address_i == `APL_OFS_TOL;
    wire s_ws   = avs_address_i == `APL_OFS_WSTART;
    wire s_we   = avs_address_i == `APL_OFS_WEND;
    wire s_mon  = avs_address_i == `APL_OFS_MON;
    wire s_st   = avs_address_i == `APL_OFS_STATUS;
    wire s_lp   = avs_address_i == `APL_OFS_LPOS;

    function automatic logic [31:0] merge(input logic [31:0] old);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = avs_byteenable_i[i] ? avs_writedata_i[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    wire        cmd_hit    = wr & s_ctrl & avs_byteenable_i[1];
    wire        cmd_latch  = cmd_hit & avs_writedata_i[`APL_CTL_LATCH];
    wire        cmd_cancel = cmd_hit & avs_writedata_i[`APL_CTL_CANCEL];
    wire        cmd_erst   = cmd_hit & avs_writedata_i[`APL_CTL_ERST];
    wire [7:0]  ctrl_w     = (wr & s_ctrl & avs_byteenable_i[0]) ? avs_writedata_i[7:0] : ctrl_q;
    wire [31:0] mon_w      = merge({22'h0, mon_q});
    // out-of-range monitor times are clamped, never stored
    wire [9:0]  mon_d      = (mon_w == 32'h0) ? `APL_MON_MIN :
                             (mon_w > {22'h0, `APL_MON_MAX}) ? `APL_MON_MAX : mon_w[9:0];
    wire [31:0] rd_mux     = s_ctrl ? {24'h0, ctrl_q} :
                             s_up   ? up_q :
                             s_lo   ? lo_q :
                             s_tol  ? tol_q :
                             s_ws   ? ws_q :
                             s_we   ? we_q :
                             s_mon  ? {22'h0, mon_q} :
                             s_st   ? {code_q, 6'h0, fl_q} :
                             s_lp   ? lpos_q : 32'h0;

    // software stroke limits
    wire        sw_dflt = up_q == `APL_SWUP_RST && lo_q == `APL_SWLO_RST;
    wire        sw_chk  = !sw_dflt && up_q != lo_q
                          && !(speed_ctl_i && !ctrl_q[`APL_CTL_SPD_DET]);
    wire        sw_out  = sw_chk && ($signed(actual_pos_i) > $signed(up_q)
                          || $signed(actual_pos_i) < $signed(lo_q));
    wire        sw_rise = sw_out & ~fl_q.sw_out;

    // tracking deviation, 33 bits so the difference cannot wrap
    wire signed [32:0] dv   = {actual_pos_i[31], actual_pos_i} - {target_pos_i[31], target_pos_i};
    wire        [32:0] dabs = dv[32] ? 33'(-dv) : 33'(dv);
    wire        trk_on  = pos_op_i && tol_q != 32'h0 && !homing_i && !torque_ctl_i;
    wire        trk_hit = trk_on && dabs > {1'b0, tol_q};
    wire        lvl_alm = ctrl_q[`APL_CTL_TRK_LVL];

    // latch window; a reversed window only means something on a rotary axis
    wire ws_le   = $signed(ws_q) <= $signed(we_q);
    wire in_lin  = $signed(actual_pos_i) >= $signed(ws_q) && $signed(actual_pos_i) <= $signed(we_q);
    wire in_wrap = $signed(actual_pos_i) >= $signed(ws_q) || $signed(actual_pos_i) <= $signed(we_q);
    wire in_win  = !ctrl_q[`APL_CTL_WIN_EN] || (ws_le ? in_lin : rotary_i && in_wrap);
    wire p_edge  = sel_q ? prs[1] : prs[0];
    wire cap     = fl_q.armed && p_edge && in_win;
    wire pdo_ok  = ctrl_w[`APL_CTL_PDO_OK];
    wire lat_ok  = cmd_latch & pdo_ok;
    wire can_hit = cmd_cancel & fl_q.armed & (sel_q == ctrl_w[`APL_CTL_PRB_SEL]);

    // operation gate
    wire hw_bad = (fl_q.hw_up && !(op_jog_i && op_dir_neg_i))
                  || (fl_q.hw_lo && !(op_jog_i && !op_dir_neg_i));
    wire rej    = op_req_i && (hw_bad || (fl_q.sw_out && !op_jog_i));

    // most severe event of this cycle owns the code; an event beats the clearing reset
    wire [15:0] code_d = rs[0] ? `APL_ERR_HWUP :
                         rs[1] ? `APL_ERR_HWLO :
                         (trk_hit && lvl_alm) ? `APL_ERR_TRK_ALM :
                         trk_hit ? `APL_ERR_TRK_WRN :
                         (cmd_latch && !pdo_ok) ? `APL_ERR_NO_PDO :
                         sw_rise ? SW_ERR_CODE :
                         cmd_erst ? 16'h0 : code_q;

    // limit flags hold until the switch is released, i.e. the jog is back inside
    assign fl_d.hw_up       = rs[0] | (fl_q.hw_up & lv[0]);
    assign fl_d.hw_lo       = rs[1] | (fl_q.hw_lo & lv[1]);
    assign fl_d.sw_out      = sw_out;
    assign fl_d.dev_warn    = (trk_hit & ~lvl_alm) | (fl_q.dev_warn & ~cmd_erst);
    assign fl_d.dev_alarm   = (trk_hit & lvl_alm) | (fl_q.dev_alarm & ~cmd_erst);
    assign fl_d.armed       = lat_ok | (fl_q.armed & ~cap & ~can_hit);
    assign fl_d.done        = cap | (fl_q.done & ~lat_ok);
    assign fl_d.cancelled   = can_hit | (fl_q.cancelled & ~lat_ok);
    assign fl_d.rst_busy    = rm_q == apl_pkg::RM_RUN;
    assign fl_d.rst_timeout = rm_q == apl_pkg::RM_EXPIRED;

    apl_tick_div #(.DIV(MS_CYCLES)) u_ms (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .clr_i     (cmd_erst),
        .tick_o    (ms_tick)
    );

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_q         <= 1'b1;
            avs_readdata_o <= 32'h0;
        end else begin
            wait_q         <= ~(req & wait_q);
            avs_readdata_o <= (avs_read_i && wait_q) ? rd_mux : avs_readdata_o;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= `APL_CTRL_RST;
            up_q   <= `APL_SWUP_RST;
            lo_q   <= `APL_SWLO_RST;
            tol_q  <= `APL_TOL_RST;
            ws_q   <= 32'h0;
            we_q   <= 32'h0;
            mon_q  <= `APL_MON_RST;
        end else if (wr) begin
            if (s_ctrl && avs_byteenable_i[0]) ctrl_q <= avs_writedata_i[7:0];
            if (s_up)  up_q  <= merge(up_q);
            if (s_lo)  lo_q  <= merge(lo_q);
            if (s_tol) tol_q <= merge(tol_q);
            if (s_ws)  ws_q  <= merge(ws_q);
            if (s_we)  we_q  <= merge(we_q);
            if (s_mon) mon_q <= mon_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fl_q   <= '0;
            code_q <= 16'h0;
            sel_q  <= 1'b0;
            lpos_q <= 32'h0;
        end else begin
            fl_q   <= fl_d;
            code_q <= code_d;
            sel_q  <= lat_ok ? ctrl_w[`APL_CTL_PRB_SEL] : sel_q;
            lpos_q <= cap ? actual_pos_i : lpos_q;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            motion_abort_o           <= 1'b0;
            sudden_stop_o            <= 1'b0;
            op_reject_o              <= 1'b0;
            deviation_warning_flag_o <= 1'b0;
            deviation_alarm_flag_o   <= 1'b0;
            error_code_out_o         <= 16'h0;
        end else begin
            motion_abort_o           <= rs[0] | rs[1];
            sudden_stop_o            <= trk_hit & lvl_alm;
            op_reject_o              <= rej;
            deviation_warning_flag_o <= fl_d.dev_warn;
            deviation_alarm_flag_o   <= fl_d.dev_alarm;
            error_code_out_o         <= code_d;
        end
    end

    // reset monitor; the drive error level is re-read each cycle so a cleared
    // error stops the repeated reset without waiting for the next ms tick
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rm_q              <= apl_pkg::RM_IDLE;
            mcnt_q            <= 10'h0;
            drive_err_reset_o <= 1'b0;
        end else if (cmd_erst) begin
            rm_q              <= apl_pkg::RM_RUN;
            mcnt_q            <= mon_q;
            drive_err_reset_o <= lv[2];
        end else begin
            case (rm_q)
                apl_pkg::RM_RUN: begin
                    if (!lv[2]) begin
                        rm_q              <= apl_pkg::RM_IDLE;
                        drive_err_reset_o <= 1'b0;
                    end else if (ms_tick && mcnt_q == 10'h1) begin
                        rm_q              <= apl_pkg::RM_EXPIRED;
                        drive_err_reset_o <= 1'b0;
                    end else begin
                        mcnt_q            <= ms_tick ? mcnt_q - 10'h1 : mcnt_q;
                        drive_err_reset_o <= 1'b1;
                    end
                end
                default: begin
                    drive_err_reset_o <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    property p_hw_code;
        rs[0] |=> error_code_out_o == `APL_ERR_HWUP && motion_abort_o;
    endproperty
    a_hw_code: assert property (p_hw_code) else $error("upper limit code missing");

    property p_abort;
        (rs[1] && !rs[0]) |=> motion_abort_o && error_code_out_o == `APL_ERR_HWLO;
    endproperty
    a_abort: assert property (p_abort) else $error("lower limit abort missing");

    property p_jog_only;
        (fl_q.hw_up && op_req_i && !(op_jog_i && op_dir_neg_i)) |=> op_reject_o;
    endproperty
    a_jog_only: assert property (p_jog_only) else $error("limit did not refuse op");

    property p_sw_refuse;
        (fl_q.sw_out && op_req_i && !op_jog_i) |=> op_reject_o;
    endproperty
    a_sw_refuse: assert property (p_sw_refuse) else $error("stroke did not refuse op");

    property p_sw_skip;
        (up_q == lo_q || (up_q == `APL_SWUP_RST && lo_q == `APL_SWLO_RST)) |=> !fl_q.sw_out;
    endproperty
    a_sw_skip: assert property (p_sw_skip) else $error("stroke checked while off");

    property p_trk_alarm;
        (trk_hit && lvl_alm) |=> sudden_stop_o && deviation_alarm_flag_o
                                 && error_code_out_o == `APL_ERR_TRK_ALM || $past(rs) != 3'h0;
    endproperty
    a_trk_alarm: assert property (p_trk_alarm) else $error("alarm stop missing");

    property p_trk_off;
        (tol_q == 32'h0 || homing_i || torque_ctl_i) |=> !sudden_stop_o;
    endproperty
    a_trk_off: assert property (p_trk_off) else $error("tracking checked while off");

    property p_capture;
        (fl_q.armed && !sel_q && prs[0] && in_win) |=> fl_q.done && lpos_q == $past(actual_pos_i);
    endproperty
    a_capture: assert property (p_capture) else $error("probe capture missing");

    property p_no_pdo;
        (cmd_latch && !pdo_ok && !fl_q.armed) |=> !fl_q.armed;
    endproperty
    a_no_pdo: assert property (p_no_pdo) else $error("latch armed without pdo");

    property p_expire;
        rm_q == apl_pkg::RM_EXPIRED && !cmd_erst |=> !drive_err_reset_o [*3];
    endproperty
    a_expire: assert property (p_expire) else $error("reset repeated after timeout");

    property p_cancel;
        can_hit && !cmd_latch |=> !fl_q.armed && fl_q.cancelled;
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel left latch armed");

endmodule : apl_axis_guard

// file: common/apl_consts.svh
/*
  register offsets, field positions, reset values, error codes and timing figures
  of the axis protection and latch block; assumes a 125 MHz system clock
*/
`ifndef APL_CONSTS_SVH
`define APL_CONSTS_SVH

// byte addresses on the register bus
`define APL_OFS_CTRL     8'h00
`define APL_OFS_SWUP     8'h04
`define APL_OFS_SWLO     8'h08
`define APL_OFS_TOL      8'h0c
`define APL_OFS_WSTART   8'h10
`define APL_OFS_WEND     8'h14
`define APL_OFS_MON      8'h18
`define APL_OFS_STATUS   8'h1c
`define APL_OFS_LPOS     8'h20

// control register: configuration bits, then write-one command bits
`define APL_CTL_TRK_LVL  0
`define APL_CTL_SPD_DET  1
`define APL_CTL_PRB_SEL  2
`define APL_CTL_WIN_EN   3
`define APL_CTL_PDO_OK   4
`define APL_CTL_LATCH    8
`define APL_CTL_CANCEL   9
`define APL_CTL_ERST     10

`define APL_CTRL_RST     8'h00
`define APL_SWUP_RST     32'h7fffffff
`define APL_SWLO_RST     32'h80000000
`define APL_TOL_RST      32'h00000000
`define APL_MON_RST      10'h064
`define APL_MON_MIN      10'h001
`define APL_MON_MAX      10'h3e8

`define APL_ERR_HWUP     16'h1200
`define APL_ERR_HWLO     16'h1201
`define APL_ERR_TRK_ALM  16'h101c
`define APL_ERR_TRK_WRN  16'h101d
`define APL_ERR_NO_PDO   16'h10e0

`define APL_CLK_NS       8
`define APL_MS_NS        1000000

`endif

// file: common/apl_pkg.sv
/*
  types shared by the axis protection and latch block;
  assumes apl_consts.svh for all numbers
*/
package apl_pkg;

    typedef enum logic [1:0] {
        RM_IDLE,
        RM_RUN,
        RM_EXPIRED
    } apl_rmon_t;

    // status flags, msb first as they appear in the status word
    typedef struct packed {
        logic hw_up;
        logic hw_lo;
        logic sw_out;
        logic dev_warn;
        logic dev_alarm;
        logic armed;
        logic done;
        logic cancelled;
        logic rst_busy;
        logic rst_timeout;
    } apl_flags_t;

endpackage : apl_pkg

// file: src/apl_sync_edge.sv
/*
  two-flop synchroniser with rising-edge detect for a group of pins;
  assumes pins are asynchronous to clk_sys_i
*/
`timescale 1ns/1ps
module apl_sync_edge #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] lvl_o,
    output logic      [W-1:0] rise_o
);
    logic [W-1:0] s1_q, s2_q, s3_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lvl_o  = s2_q;
    assign rise_o = s2_q & ~s3_q;
endmodule : apl_sync_edge

// file: src/apl_tick_div.sv
/*
  divider giving a one-cycle enable every DIV clocks, restartable;
  assumes DIV of at least 2
*/
`timescale 1ns/1ps
module apl_tick_div #(
    parameter int unsigned DIV = 2
) (
    input  wire logic clk_sys_i,
    input  wire logic arst_n_i,
    input  wire logic clr_i,
    output logic      tick_o
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt_q;
    wire          last = cnt_q == W'(DIV - 1);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= (clr_i || last) ? '0 : cnt_q + W'(1);
            tick_o <= !clr_i && last;
        end
    end
endmodule : apl_tick_div

// file: sim/apl_drive_model.sv
/*
  servo drive stand-in: limit, probe and fault pins plus the actual axis position;
  assumes the bench requests pin levels and positions on clk_sys_i
*/
`timescale 1ns/1ps
module apl_drive_model (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic [4:0]  ev_i,
    input  wire logic [31:0] pos_i,
    output logic      [4:0]  pins_o,
    output logic      [31:0] pos_o,
    output logic             pdo_ok_o
);
    // probe function, status and captured position always travel in the cyclic data
    assign pdo_ok_o = 1'b1;
    // a tripped switch blocks travel further into it, travel away stays free
    wire logic up_blk = pins_o[0] && ($signed(pos_i) > $signed(pos_o));
    wire logic lo_blk = pins_o[1] && ($signed(pos_i) < $signed(pos_o));
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pins_o <= 5'h00;
            pos_o  <= 32'h00000000;
        end else begin
            pins_o <= ev_i;
            pos_o  <= (up_blk || lo_blk) ? pos_o : pos_i;
        end
    end
endmodule : apl_drive_model

// file: sim/apl_axis_guard_tb_top.sv
/*
  directed bench of the axis guard: avalon-mm tasks, drive stand-in, checks;
  assumes MS_CYCLES cut to 10 clocks per millisecond
*/
`timescale 1ns/1ps
`include "apl_consts.svh"
module apl_axis_guard_tb_top;
    logic            clk_sys_i = 1'b0, arst_n_i = 1'b0;
    logic [7:0]      avs_address_i = 8'h00;
    logic            avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [31:0]     avs_writedata_i = 32'h0, target_pos_i = 32'h0, mpos = 32'h0;
    logic [4:0]      ev = 5'h00;
    logic            pos_op_i = 1'b0, speed_ctl_i = 1'b0, homing_i = 1'b0, torque_ctl_i = 1'b0, rotary_i = 1'b0;
    logic            op_req_i = 1'b0, op_jog_i = 1'b0, op_dir_neg_i = 1'b0;
    wire logic [3:0] avs_byteenable_i = 4'hf;
    wire logic [31:0] avs_readdata_o, actual_pos_i;
    wire logic [15:0] error_code_out_o;
    wire logic [4:0] pins;
    wire logic       avs_waitrequest_o, motion_abort_o, sudden_stop_o, op_reject_o, drive_err_reset_o;
    wire logic       deviation_warning_flag_o, deviation_alarm_flag_o, pdo;
    wire logic       hw_upper_i, hw_lower_i, probe1_i, probe2_i, drive_err_i;
    wire logic [3:0] pulse = {drive_err_reset_o, sudden_stop_o, op_reject_o, motion_abort_o};
    wire logic [31:0] lat = {23'h0, 1'b1, 3'h0, pdo, 4'h0};
    logic [7:0]      ra [5] = '{`APL_OFS_SWUP, `APL_OFS_SWLO, `APL_OFS_TOL, `APL_OFS_MON, 8'h40};
    logic [31:0]     rv [5] = '{32'h7fffffff, 32'h80000000, 32'h0, 32'h64, 32'h0};
    int              n_errors = 0, samples_checked = 0, cyc = 0;
    assign {drive_err_i, probe2_i, probe1_i, hw_lower_i, hw_upper_i} = pins;

    initial forever #4 clk_sys_i = ~clk_sys_i;

    apl_axis_guard #(.MS_CYCLES(10)) DUT (.clk_sys_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .actual_pos_i,
        .target_pos_i, .pos_op_i, .speed_ctl_i, .homing_i, .torque_ctl_i, .rotary_i, .op_req_i, .op_jog_i,
        .op_dir_neg_i, .hw_upper_i, .hw_lower_i, .probe1_i, .probe2_i, .drive_err_i, .motion_abort_o,
        .sudden_stop_o, .op_reject_o, .drive_err_reset_o, .deviation_warning_flag_o,
        .deviation_alarm_flag_o, .error_code_out_o);
    apl_drive_model u_drive (.clk_sys_i, .arst_n_i, .ev_i(ev), .pos_i(mpos), .pins_o(pins),
        .pos_o(actual_pos_i), .pdo_ok_o(pdo));

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic st(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : st

    // request held until waitrequest is seen low, released only after that edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys_i);
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        r = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : acc

    task automatic watch(input int k, input int n, output logic s);
        s = 1'b0;
        repeat (n) begin
            @(negedge clk_sys_i);
            if (pulse[k] === 1'b1) s = 1'b1;
        end
        @(posedge clk_sys_i);
    endtask : watch

    task automatic op(input logic j, input logic ng, input logic exp, input string nm);
        logic s;
        st(4);
        op_req_i <= 1'b1;
        op_jog_i <= j;
        op_dir_neg_i <= ng;
        @(posedge clk_sys_i);
        op_req_i <= 1'b0;
        watch(1, 3, s);
        chk(nm, 32'(s), 32'(exp));
    endtask : op

    task automatic pr(input int k);
        ev[k] <= 1'b1;
        st(3);
        ev[k] <= 1'b0;
        st(6);
    endtask : pr

    task automatic lp(input logic [31:0] exp, input string nm);
        logic [31:0] r;
        acc(1'b0, `APL_OFS_LPOS, 32'h0, r);
        chk(nm, r, exp);
    endtask : lp

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        logic [31:0] r;
        logic        s;
        st(3);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, ra[i], 32'h0, r);
            chk("reset value", r, rv[i]);
        end
        acc(1'b1, `APL_OFS_MON, 32'h000007d0, r);
        acc(1'b0, `APL_OFS_MON, 32'h0, r);
        chk("mon upper clamp", r, 32'h000003e8);
        acc(1'b1, `APL_OFS_MON, 32'h0, r);
        acc(1'b0, `APL_OFS_MON, 32'h0, r);
        chk("mon lower clamp", r, 32'h00000001);
        acc(1'b1, `APL_OFS_SWUP, 32'h000003e8, r);
        acc(1'b1, `APL_OFS_SWLO, 32'hfffffc18, r);
        mpos <= 32'h000007d0;
        op(1'b0, 1'b0, 1'b1, "stroke op");
        chk("stroke code", 32'(error_code_out_o), 32'h00000001);
        op(1'b1, 1'b0, 1'b0, "stroke jog");
        speed_ctl_i <= 1'b1;
        op(1'b0, 1'b0, 1'b0, "speed control op");
        speed_ctl_i <= 1'b0;
        acc(1'b1, `APL_OFS_SWLO, 32'h000003e8, r);
        op(1'b0, 1'b0, 1'b0, "equal limits op");
        mpos <= 32'h0;
        for (int i = 0; i < 2; i++) begin
            ev[i] <= 1'b1;
            watch(0, 10, s);
            chk("limit abort", 32'(s), 32'h1);
            chk("limit code", 32'(error_code_out_o), 32'h1200 + i);
            op(1'b0, 1'b0, 1'b1, "limit op");
            op(1'b1, i == 0, 1'b0, "limit jog away");
            op(1'b1, i != 0, 1'b1, "limit jog into");
            ev[i] <= 1'b0;
        end
        acc(1'b1, `APL_OFS_TOL, 32'h0000000a, r);
        pos_op_i <= 1'b1;
        mpos <= 32'h0000000a;
        st(6);
        chk("tolerance edge", 32'(deviation_warning_flag_o), 32'h0);
        mpos <= 32'h0000000b;
        st(6);
        chk("warn flag", 32'(deviation_warning_flag_o), 32'h1);
        chk("warn code", 32'(error_code_out_o), 32'h101d);
        chk("warn runs on", 32'(sudden_stop_o), 32'h0);
        acc(1'b1, `APL_OFS_CTRL, 32'h00000401, r);
        st(4);
        chk("alarm flags", {deviation_alarm_flag_o, sudden_stop_o, deviation_warning_flag_o}, 3'b111);
        chk("alarm code", 32'(error_code_out_o), 32'h101c);
        homing_i <= 1'b1;
        st(2);
        acc(1'b1, `APL_OFS_CTRL, 32'h00000401, r);
        st(4);
        chk("homing skip", {deviation_alarm_flag_o, sudden_stop_o}, 2'b00);
        homing_i <= 1'b0;
        torque_ctl_i <= 1'b1;
        st(4);
        chk("torque skip", {deviation_alarm_flag_o, sudden_stop_o}, 2'b00);
        torque_ctl_i <= 1'b0;
        acc(1'b1, `APL_OFS_TOL, 32'h0, r);
        acc(1'b1, `APL_OFS_CTRL, 32'h00000401, r);
        st(4);
        chk("zero tolerance skip", {deviation_alarm_flag_o, sudden_stop_o}, 2'b00);
        pos_op_i <= 1'b0;
        mpos <= 32'h00000123;
        acc(1'b1, `APL_OFS_CTRL, lat, r);
        pr(2);
        lp(32'h00000123, "probe1 capture");
        acc(1'b1, `APL_OFS_CTRL, lat | 32'h4, r);
        mpos <= 32'h00000456;
        pr(2);
        mpos <= 32'h00000789;
        pr(3);
        lp(32'h00000789, "probe2 capture");
        acc(1'b1, `APL_OFS_WSTART, 32'h00000100, r);
        acc(1'b1, `APL_OFS_WEND, 32'h00000200, r);
        acc(1'b1, `APL_OFS_CTRL, lat | 32'h8, r);
        mpos <= 32'h00000300;
        pr(2);
        mpos <= 32'h00000150;
        pr(2);
        lp(32'h00000150, "window capture");
        rotary_i <= 1'b1;
        acc(1'b1, `APL_OFS_WSTART, 32'h00000300, r);
        acc(1'b1, `APL_OFS_CTRL, lat | 32'h8, r);
        mpos <= 32'h00000250;
        pr(2);
        mpos <= 32'h00000380;
        pr(2);
        lp(32'h00000380, "wrapped window capture");
        acc(1'b1, `APL_OFS_CTRL, lat, r);
        acc(1'b1, `APL_OFS_CTRL, lat ^ 32'h300, r);
        mpos <= 32'h00000222;
        pr(2);
        lp(32'h00000380, "cancelled latch");
        acc(1'b1, `APL_OFS_CTRL, 32'h00000100, r);
        st(2);
        chk("unmapped probe data", 32'(error_code_out_o), 32'h10e0);
        ev[4] <= 1'b1;
        st(4);
        acc(1'b1, `APL_OFS_CTRL, 32'h00000400, r);
        watch(3, 3, s);
        chk("reset repeats", 32'(s), 32'h1);
        st(12);
        chk("reset gives up", 32'(drive_err_reset_o), 32'h0);
        acc(1'b0, `APL_OFS_STATUS, 32'h0, r);
        chk("reset timeout", 32'(r[0]), 32'h1);
        summarize();
    end
endmodule : apl_axis_guard_tb_top
